//--- core/urg_consts.svh
// Constants for the user reset generator: timing figures and derived cycle counts.
// Assumes a single system clock whose period is given below.
`ifndef URG_CONSTS_SVH
`define URG_CONSTS_SVH

// ----------------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------------
`define URG_CLK_PERIOD_PS    4000

// ----------------------------------------------------------------------------
// Phase times in nanoseconds and their least cycle counts (rounded up)
// ----------------------------------------------------------------------------
`define URG_BOOT_TIME_NS     400
`define URG_INIT_TIME_NS     800
`define URG_STEP_TIME_NS     40
`define URG_CYCLES(t_ns)     (((t_ns) * 1000 + `URG_CLK_PERIOD_PS - 1) / `URG_CLK_PERIOD_PS)
`define URG_BOOT_CYCLES      `URG_CYCLES(`URG_BOOT_TIME_NS)
`define URG_INIT_CYCLES      `URG_CYCLES(`URG_INIT_TIME_NS)
`define URG_STEP_CYCLES      `URG_CYCLES(`URG_STEP_TIME_NS)

// ----------------------------------------------------------------------------
// Structure
// ----------------------------------------------------------------------------
`define URG_RELEASE_STAGES   2
`define URG_CORE_SUPPLIES    3
`define URG_DIV_HALF         4
`define URG_CNT_W            16

`endif

//--- core/urg_pkg.sv
// Types shared by both ends of the user reset generator.
// Assumes nothing beyond a SystemVerilog compiler.
package urg_pkg;

    // ------------------------------------------------------------------------
    // Device phases, one-hot
    // ------------------------------------------------------------------------
    typedef enum logic [6:0] {
        URG_POR        = 7'h01,
        URG_BOOT       = 7'h02,
        URG_INIT       = 7'h04,
        URG_RUN        = 7'h08,
        URG_IO_OFF     = 7'h10,
        URG_FABRIC_OFF = 7'h20,
        URG_PERIPH_RST = 7'h40
    } urg_state_t;

endpackage

//--- core/urg_if.sv
// Link between the device end (monitor and reset generator) and the user end.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps

interface urg_if (
    input wire logic clk_sys
);
    logic fabric_por_n;           // Low while the fabric is held in power-on reset.
    logic bank_supply_ok;         // IO bank supply is present.
    logic serdes_setup_complete;  // Transceivers configured.
    logic device_setup_complete;  // Whole device initialisation finished.
    logic hsio_ready;             // High-speed IO usable.
    logic user_reset_n;           // Generated reset, low active.
    logic ext_reset_req;          // Qualified external reset request.
    logic pll_locked;             // Synchronised PLL lock.
    logic fabric_reset_request;   // Fabric asks for a full device reset.

    modport dev (
        input  clk_sys, ext_reset_req, pll_locked, fabric_reset_request,
        output fabric_por_n, bank_supply_ok, serdes_setup_complete,
               device_setup_complete, hsio_ready, user_reset_n
    );

    modport usr (
        input  clk_sys, fabric_por_n, bank_supply_ok, serdes_setup_complete,
               device_setup_complete, hsio_ready, user_reset_n,
        output ext_reset_req, pll_locked, fabric_reset_request
    );
endinterface

//--- core/urg_device.sv
// Device end: power-on supervisor, system-controller sequence, init monitor and
// the reset generator that merges all sources into one user reset.
// Assumes the pins below are asynchronous and the link partner shares clk_sys.
//
// How it works
// [R1] Ignore external reset until POR off, bank up.
// [R2] Hold PLL down until POR off, bank up.
// [R3] Reconfig clock divider flop cleared by POR.
// [R4] Reconfig select flop cleared asynchronously by POR.
// [R5] Never use raw PLL lock as reset.
// [R6] Assert reset asynchronously, release synchronously.
// [R7] All downstream flops leave reset together.
// [R8] Any active reset source holds output reset.
// [R9] Setup-complete rises only after full initialisation.
// [R10] Reset order: IOs off, fabric off, peripherals.
// [R11] Pin reset causes full device re-initialisation.
// [R12] Release on supplies good; reset on drop.
// [R13] External reset driver holds pin until stable.
// [R14] User applies reset pulse to fabric flops.
// [R15] IO buffers disabled during power-on reset.
// [R16] RAMs loaded only during init, if configured.
// [R17] High-speed IO needs calibration and supplies.
// [R18] Transceiver-clocked logic waits for transceiver setup.
// [R19] Reconfig clock gated until device setup complete.
// [R20] Release path uses two or more stages.
`timescale 1ns/1ps
`include "urg_consts.svh"

module urg_device #(
    parameter int BOOT_CYCLES    = `URG_BOOT_CYCLES,
    parameter int INIT_CYCLES    = `URG_INIT_CYCLES,
    parameter int STEP_CYCLES    = `URG_STEP_CYCLES,
    parameter int RELEASE_STAGES = `URG_RELEASE_STAGES,
    parameter bit RAM_INIT_EN    = 1'b1
) (
    input  wire logic                           clk_sys,
    input  wire logic                           reset,
    input  wire logic [`URG_CORE_SUPPLIES-1:0]  core_supply_ok,
    input  wire logic                           device_reset_pin_n,
    input  wire logic                           bank_supply_pin,
    input  wire logic                           aux_supply_pin,
    input  wire logic                           io_calib_done_pin,
    output logic                                io_enable,
    output logic                                fabric_powered,
    output logic                                periph_reset,
    output logic                                ram_loaded,
    output urg_pkg::urg_state_t                 dev_phase,
    urg_if.dev                                  lnk
);
    import urg_pkg::*;

    localparam int PW = `URG_CORE_SUPPLIES + 4;

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    logic [PW-1:0]            pin_s1;
    logic [PW-1:0]            pin_s2;
    logic [`URG_CNT_W-1:0]    cnt;
    urg_state_t               state;
    urg_state_t               next_state;
    logic                     gen_hold;
    logic [RELEASE_STAGES-1:0] rel_chain;

    // Every pin passes two flops; only the second stage is read below.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else begin
            pin_s1 <= {io_calib_done_pin, aux_supply_pin, bank_supply_pin,
                       device_reset_pin_n, core_supply_ok};
            pin_s2 <= pin_s1;
        end
    end

    wire supplies_ok  = &pin_s2[`URG_CORE_SUPPLIES-1:0];
    wire pin_rst      = ~pin_s2[`URG_CORE_SUPPLIES];
    wire bank_ok      = pin_s2[`URG_CORE_SUPPLIES+1];
    wire aux_ok       = pin_s2[`URG_CORE_SUPPLIES+2];
    wire calib_ok     = pin_s2[`URG_CORE_SUPPLIES+3];

    // ------------------------------------------------------------------------
    // System controller sequence
    // ------------------------------------------------------------------------
    // A supply drop, the pin or a fabric request all start the same teardown.
    wire dev_reset_req = ~supplies_ok | pin_rst | lnk.fabric_reset_request; // R12
    wire boot_done     = (cnt == 16'(BOOT_CYCLES - 1));
    wire init_done     = (cnt == 16'(INIT_CYCLES - 1));
    wire step_done     = (cnt >= 16'(STEP_CYCLES - 1)); // Stays true while a step is held, until cnt wraps to zero after 65536 cycles.
    wire active_phase  = (state == URG_BOOT) | (state == URG_INIT) | (state == URG_RUN);

    always_comb begin
        next_state = state;
        case (state)
            URG_POR: begin
                if (supplies_ok && !pin_rst) begin
                    next_state = URG_BOOT; // R12
                end
            end
            URG_BOOT: begin
                if (boot_done) begin
                    next_state = URG_INIT;
                end
            end
            URG_INIT: begin
                if (init_done) begin
                    next_state = URG_RUN;
                end
            end
            URG_RUN: begin
                next_state = URG_RUN;
            end
            URG_IO_OFF: begin
                if (step_done) begin
                    next_state = URG_FABRIC_OFF; // R10
                end
            end
            URG_FABRIC_OFF: begin
                if (step_done) begin
                    next_state = URG_PERIPH_RST; // R10
                end
            end
            URG_PERIPH_RST: begin
                // Return to power-on so the whole device re-initialises.
                if (step_done && !pin_rst) begin
                    next_state = URG_POR; // R11
                end
            end
            default: begin
                next_state = URG_POR;
            end
        endcase
        if (active_phase && dev_reset_req) begin
            next_state = URG_IO_OFF; // R10
        end
    end

    wire [`URG_CNT_W-1:0] next_cnt = (next_state != state) ? '0 : cnt + 16'h0001;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state <= URG_POR;
            cnt   <= '0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // ------------------------------------------------------------------------
    // Block states and monitor outputs
    // ------------------------------------------------------------------------
    // IO buffers stay off in power-on and through the whole teardown.
    wire next_io_enable   = (next_state == URG_INIT) | (next_state == URG_RUN); // R15
    wire next_fabric_pwr  = (next_state == URG_BOOT) | (next_state == URG_INIT)
                          | (next_state == URG_RUN)  | (next_state == URG_IO_OFF);
    wire next_periph_rst  = (next_state == URG_PERIPH_RST) | (next_state == URG_POR);
    // RAMs are powered but empty during boot; contents appear only once init ran.
    wire next_ram_loaded  = RAM_INIT_EN & (next_state == URG_RUN); // R16
    wire next_serdes_done = (next_state == URG_RUN); // R9
    wire next_dev_done    = (next_state == URG_RUN); // R9
    wire next_hsio_ready  = (next_state == URG_RUN) & calib_ok & bank_ok & aux_ok; // R17
    wire next_por_n       = (next_state == URG_INIT) | (next_state == URG_RUN);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            io_enable                 <= 1'b0;
            fabric_powered            <= 1'b0;
            periph_reset              <= 1'b1;
            ram_loaded                <= 1'b0;
            dev_phase                 <= URG_POR;
            lnk.fabric_por_n          <= 1'b0;
            lnk.bank_supply_ok        <= 1'b0;
            lnk.serdes_setup_complete <= 1'b0;
            lnk.device_setup_complete <= 1'b0;
            lnk.hsio_ready            <= 1'b0;
        end else begin
            io_enable                 <= next_io_enable;
            fabric_powered            <= next_fabric_pwr;
            periph_reset              <= next_periph_rst;
            ram_loaded                <= next_ram_loaded;
            dev_phase                 <= next_state;
            lnk.fabric_por_n          <= next_por_n;
            lnk.bank_supply_ok        <= bank_ok;
            lnk.serdes_setup_complete <= next_serdes_done;
            lnk.device_setup_complete <= next_dev_done;
            lnk.hsio_ready            <= next_hsio_ready;
        end
    end

    // ------------------------------------------------------------------------
    // Reset generator
    // ------------------------------------------------------------------------
    // The merged source is registered so the asynchronous clear cannot glitch.
    // The lock arrives synchronised and clk_sys runs free, so the release chain
    // sees edges even while the PLL is silent.
    wire next_gen_hold = reset | ~lnk.device_setup_complete | lnk.ext_reset_req
                       | ~lnk.pll_locked; // R8 R5

    always_ff @(posedge clk_sys) begin
        gen_hold <= next_gen_hold;
    end

    // Clear at once on any source, shift ones in on clk_sys for the release.
    always_ff @(posedge clk_sys or posedge gen_hold) begin
        if (gen_hold) begin
            rel_chain <= '0; // R6
        end else begin
            rel_chain <= {rel_chain[RELEASE_STAGES-2:0], 1'b1}; // R20
        end
    end

    // One flop fans out the release, so every consumer leaves reset together.
    assign lnk.user_reset_n = rel_chain[RELEASE_STAGES-1]; // R7

endmodule

//--- core/urg_user.sv
// User end: downstream fabric logic that qualifies its external reset, holds its
// PLL down, makes the reconfiguration clock and select, and consumes the reset.
// Assumes the device end drives the link from clk_sys flops.
`timescale 1ns/1ps
`include "urg_consts.svh"

module urg_user #(
    parameter int DIV_HALF = `URG_DIV_HALF
) (
    input  wire logic  clk_sys,
    input  wire logic  reset,
    input  wire logic  external_reset_n,
    input  wire logic  pll_lock_pin,
    input  wire logic  reconfig_request,
    input  wire logic  device_reset_request,
    output logic       pll_power_down,
    output logic       dyn_reconfig_clock,
    output logic       dyn_reconfig_select,
    output logic       serdes_domain_reset,
    output logic       app_ready,
    urg_if.usr         lnk
);
    import urg_pkg::*;

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic [7:0] div_cnt;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pin_s1 <= 2'h3;
            pin_s2 <= 2'h3;
        end else begin
            pin_s1 <= {pll_lock_pin, external_reset_n};
            pin_s2 <= pin_s1;
        end
    end

    // ------------------------------------------------------------------------
    // Qualification and requests to the device end
    // ------------------------------------------------------------------------
    // The input buffer is untrusted until power-on ends and its bank has supply.
    wire buffers_ok         = lnk.fabric_por_n & lnk.bank_supply_ok;
    wire next_ext_req       = buffers_ok & ~pin_s2[0]; // R1
    // Lock is only forwarded synchronised, never used as a reset here.
    wire next_pll_locked    = pin_s2[1] & ~pll_power_down; // R5
    wire next_pll_pd        = ~buffers_ok; // R2
    wire next_serdes_rst    = ~lnk.serdes_setup_complete | ~lnk.user_reset_n; // R18

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            lnk.ext_reset_req        <= 1'b0;
            lnk.pll_locked           <= 1'b0;
            lnk.fabric_reset_request <= 1'b0;
            pll_power_down           <= 1'b1;
            serdes_domain_reset      <= 1'b1;
        end else begin
            lnk.ext_reset_req        <= next_ext_req;
            lnk.pll_locked           <= next_pll_locked;
            lnk.fabric_reset_request <= device_reset_request;
            pll_power_down           <= next_pll_pd;
            serdes_domain_reset      <= next_serdes_rst;
        end
    end

    // ------------------------------------------------------------------------
    // Reconfiguration clock and select
    // ------------------------------------------------------------------------
    // These flops must be known before any synchronous reset can act, hence
    // the asynchronous clear from power-on.
    wire div_wrap = (div_cnt == 8'(DIV_HALF - 1));

    always_ff @(posedge clk_sys or negedge lnk.fabric_por_n) begin
        if (!lnk.fabric_por_n) begin
            div_cnt            <= 8'h00; // R3
            dyn_reconfig_clock <= 1'b0; // R3
        end else if (!lnk.device_setup_complete) begin
            div_cnt            <= 8'h00; // R19
            dyn_reconfig_clock <= 1'b0; // R19
        end else begin
            div_cnt            <= div_wrap ? 8'h00 : div_cnt + 8'h01;
            dyn_reconfig_clock <= dyn_reconfig_clock ^ div_wrap;
        end
    end

    always_ff @(posedge clk_sys or negedge lnk.fabric_por_n) begin
        if (!lnk.fabric_por_n) begin
            dyn_reconfig_select <= 1'b0; // R4
        end else begin
            dyn_reconfig_select <= reconfig_request & lnk.device_setup_complete;
        end
    end

    // ------------------------------------------------------------------------
    // Application logic brought to a known state by the generated reset
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!lnk.user_reset_n) begin
            app_ready <= 1'b0; // R14
        end else begin
            app_ready <= 1'b1;
        end
    end

endmodule

//--- verification/urg_props.sv
// Checker for the link between the device end and the user end of the reset generator.
// Assumes the bench instantiates it beside the link, on the same clock and reset.
`timescale 1ns/1ps

module urg_props (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic fabric_por_n,
    input wire logic bank_supply_ok,
    input wire logic serdes_setup_complete,
    input wire logic device_setup_complete,
    input wire logic hsio_ready,
    input wire logic user_reset_n,
    input wire logic ext_reset_req,
    input wire logic pll_locked,
    input wire logic fabric_reset_request
);
    // Any source that must keep the user reset asserted, and its inverse.
    wire hold_src = ext_reset_req | ~pll_locked | ~device_setup_complete;
    wire clr      = ~hold_src;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    src_holds_a: assert property (hold_src |=> !user_reset_n)
        else $error("user reset not asserted by an active source");
    release_a: assert property (clr [*3] |=> user_reset_n)
        else $error("user reset not released after sources cleared");
    stages_a: assert property ($rose(user_reset_n) |-> $past(clr, 2) && $past(clr, 3))
        else $error("user reset released with too few stages");
    fall_cause_a: assert property ($fell(user_reset_n) |-> $past(hold_src))
        else $error("user reset fell without a source");
    ext_qual_a: assert property (ext_reset_req |-> $past(fabric_por_n) && $past(bank_supply_ok))
        else $error("external reset taken before its buffer was usable");
    // The lock trails the qualifiers by the power-down flop and its own flop.
    pll_hold_a: assert property (pll_locked |->
        $past(fabric_por_n, 2) && $past(bank_supply_ok, 2))
        else $error("pll lock passed while pll held down");
    down_clear_a: assert property (!fabric_por_n |->
        !device_setup_complete && !serdes_setup_complete && !hsio_ready)
        else $error("done flags high while fabric in power-on reset");
    hsio_a: assert property (hsio_ready |-> device_setup_complete)
        else $error("high-speed io ready before device setup");
    setup_a: assert property ($rose(device_setup_complete) |-> $past(fabric_por_n, 4))
        else $error("setup complete without initialisation phase");
    teardown_a: assert property (fabric_reset_request && device_setup_complete
        |-> ##[1:8] !device_setup_complete)
        else $error("fabric reset request did not tear down the device");

    // ------------------------------------------------------------------------
    // Covers
    // ------------------------------------------------------------------------
    release_c: cover property ($rose(user_reset_n));
    ext_c: cover property ($rose(ext_reset_req));
    down_c: cover property ($fell(fabric_por_n));
endmodule

//--- verification/fabric_user_reset_generator_tb.sv
// Bench for both ends of the reset generator joined by their link.
// Assumes short phase counts; a queue model checks phase order and lengths.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end

module fabric_user_reset_generator_tb;
    import urg_pkg::*;
    localparam int BOOT = 4;
    localparam int INIT = 6;
    localparam int STEP = 2;
    localparam int DIVH = 4;
    logic       clk_sys, reset, pin_n, bank_pin, aux_pin, calib_pin;
    logic [2:0] core_ok;
    logic       ext_n, lock_pin, rcfg_req, dev_req, prev_dsc, c0;
    logic       io_enable, fabric_powered, periph_reset, ram_loaded;
    logic       pll_power_down, dyn_clk, dyn_sel, serdes_rst, app_ready;
    urg_state_t dev_phase, last;
    urg_state_t q_ph[$];
    int         q_len[$];
    int         mismatches, n_tests, run, n, len, tog;
    logic [31:0] seed;

    urg_if urg_if_i (.clk_sys(clk_sys));
    urg_device #(.BOOT_CYCLES(BOOT), .INIT_CYCLES(INIT), .STEP_CYCLES(STEP),
        .RELEASE_STAGES(2), .RAM_INIT_EN(1'b1)) urg_device_i (
        .clk_sys(clk_sys), .reset(reset), .core_supply_ok(core_ok),
        .device_reset_pin_n(pin_n), .bank_supply_pin(bank_pin), .aux_supply_pin(aux_pin),
        .io_calib_done_pin(calib_pin), .io_enable(io_enable), .fabric_powered(fabric_powered),
        .periph_reset(periph_reset), .ram_loaded(ram_loaded), .dev_phase(dev_phase),
        .lnk(urg_if_i));
    urg_user #(.DIV_HALF(DIVH)) urg_user_i (
        .clk_sys(clk_sys), .reset(reset), .external_reset_n(ext_n), .pll_lock_pin(lock_pin),
        .reconfig_request(rcfg_req), .device_reset_request(dev_req),
        .pll_power_down(pll_power_down), .dyn_reconfig_clock(dyn_clk),
        .dyn_reconfig_select(dyn_sel), .serdes_domain_reset(serdes_rst),
        .app_ready(app_ready), .lnk(urg_if_i));
    urg_props urg_props_i (
        .clk_sys(clk_sys), .reset(reset), .fabric_por_n(urg_if_i.fabric_por_n),
        .bank_supply_ok(urg_if_i.bank_supply_ok), .hsio_ready(urg_if_i.hsio_ready),
        .serdes_setup_complete(urg_if_i.serdes_setup_complete),
        .device_setup_complete(urg_if_i.device_setup_complete),
        .user_reset_n(urg_if_i.user_reset_n), .ext_reset_req(urg_if_i.ext_reset_req),
        .pll_locked(urg_if_i.pll_locked), .fabric_reset_request(urg_if_i.fabric_reset_request));

    // ------------------------------------------------------------------------
    // Model
    // ------------------------------------------------------------------------
    // Expected {io_enable, fabric_powered, periph_reset, ram_loaded} per phase.
    function automatic logic [3:0] outs(input urg_state_t p);
        case (p)
            URG_INIT: return 4'hC;
            URG_RUN: return 4'hD;
            URG_BOOT, URG_IO_OFF: return 4'h4;
            URG_FABRIC_OFF: return 4'h0;
            default: return 4'h2;
        endcase
    endfunction

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Sampled mid-cycle so that the edge's updates have landed; each finished
    // phase is queued with the number of cycles it lasted.
    always @(negedge clk_sys) begin
        if (reset) begin
            last = URG_POR;
            run = 0;
            q_ph.delete();
            q_len.delete();
        end else begin
            `CHK({io_enable, fabric_powered, periph_reset, ram_loaded}, outs(dev_phase))
            if (urg_if_i.fabric_por_n === 1'b0) `CHK({dyn_clk, dyn_sel}, 2'b00)
            if (prev_dsc === 1'b0 && urg_if_i.device_setup_complete === 1'b0) `CHK(dyn_clk, 1'b0)
            if (dev_phase !== last) begin
                q_ph.push_back(last);
                q_len.push_back(run);
                last = dev_phase;
                run = 1;
            end else run++;
        end
        prev_dsc = urg_if_i.device_setup_complete;
    end

    // ------------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------------
    // Pops one finished phase; a length of zero means the length is free.
    task automatic pop(input urg_state_t p, input int ln);
        urg_state_t g;
        int         d;
        `CHK(q_ph.size() != 0, 1'b1)
        if (q_ph.size() != 0) begin
            g = q_ph.pop_front();
            d = q_len.pop_front();
            `CHK(g, p)
            if (ln > 0) `CHK(d, ln)
        end
    endtask

    task automatic wait_run();
        n = 0;
        while ((dev_phase !== URG_RUN || urg_if_i.user_reset_n !== 1'b1) && n < 400) begin
            @(negedge clk_sys);
            n++;
        end
        `CHK(n < 400, 1'b1)
        @(negedge clk_sys);
    endtask

    task automatic wait_rel();
        n = 0;
        while (urg_if_i.user_reset_n !== 1'b1 && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Clock, watchdog and tests
    // ------------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // The tests take well under a thousand cycles; this span leaves a wide margin.
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        $display("[ERR] %0t watchdog expired", $time);
        end_sim();
    end

    initial begin
        {reset, pin_n, bank_pin, aux_pin, calib_pin, ext_n, lock_pin} = 7'h7F;
        {core_ok, rcfg_req, dev_req} = 5'h00;
        seed = 32'h4BF9;
        repeat (6) @(negedge clk_sys);
        reset = 1'b0;
        repeat (4) @(negedge clk_sys);
        `CHK(dev_phase, URG_POR)
        core_ok = 3'h7;
        wait_run();
        pop(URG_POR, 0);
        pop(URG_BOOT, BOOT);
        pop(URG_INIT, INIT);
        `CHK({app_ready, serdes_rst, pll_power_down, urg_if_i.hsio_ready}, 4'h9)
        $display("test power-up done");
        rcfg_req = 1'b1;
        tog = 0;
        c0 = dyn_clk;
        repeat (8 * DIVH) begin
            @(negedge clk_sys);
            if (dyn_clk !== c0) tog++;
            c0 = dyn_clk;
        end
        `CHK(tog, 8)
        `CHK(dyn_sel, 1'b1)
        rcfg_req = 1'b0;
        $display("test reconfig done");
        seed = lfsr(seed);
        len = 6 + seed[2:0];
        ext_n = 1'b0;
        repeat (len) @(negedge clk_sys);
        `CHK({urg_if_i.user_reset_n, serdes_rst, dev_phase}, {2'b01, URG_RUN})
        ext_n = 1'b1;
        wait_rel();
        `CHK(n, 6)
        lock_pin = 1'b0;
        repeat (6) @(negedge clk_sys);
        `CHK(urg_if_i.user_reset_n, 1'b0)
        lock_pin = 1'b1;
        wait_rel();
        `CHK(n, 6)
        $display("test reset sources done");
        for (int k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            if (k == 0) pin_n = 1'b0;
            else if (k == 1) core_ok = ~(3'h1 << (seed % 3));
            else dev_req = 1'b1;
            repeat (4) @(negedge clk_sys);
            dev_req = 1'b0;
            repeat (6 * STEP + 8) @(negedge clk_sys);
            if (k < 2) `CHK(dev_phase, (k == 0) ? URG_PERIPH_RST : URG_POR)
            pin_n = 1'b1;
            core_ok = 3'h7;
            wait_run();
            pop(URG_RUN, 0);
            pop(URG_IO_OFF, STEP);
            pop(URG_FABRIC_OFF, STEP);
            pop(URG_PERIPH_RST, 0);
            pop(URG_POR, 0);
            pop(URG_BOOT, BOOT);
            pop(URG_INIT, INIT);
            $display("test teardown %0d done", k);
        end
        {bank_pin, ext_n, calib_pin} = 3'h0;
        repeat (8) @(negedge clk_sys);
        `CHK({pll_power_down, urg_if_i.ext_reset_req, urg_if_i.hsio_ready}, 3'h4)
        {bank_pin, ext_n, calib_pin} = 3'h7;
        wait_run();
        $display("test bank qualify done");
        reset = 1'b1;
        repeat (6) @(negedge clk_sys);
        `CHK({dev_phase, urg_if_i.user_reset_n}, {URG_POR, 1'b0})
        reset = 1'b0;
        wait_run();
        pop(URG_POR, 0);
        pop(URG_BOOT, BOOT);
        pop(URG_INIT, INIT);
        $display("test mid-run reset done");
        end_sim();
    end
endmodule
